// *** dv/wlr_bank_assertions.sv ***
// Checker of read timing, reserved bits and warning latching at the bank's ports.
`timescale 1ns/100ps
`default_nettype none
module wlr_bank_chk
   import wlr_pkg::*;
(
   // Ports watched
   input wire logic        SYS_CLK,
   input wire logic        RSTN,
   input wire logic        RD_EN,
   input wire logic [7:0]  CMD,
   input wire logic [15:0] RD_DATA,
   input wire logic        RD_VALID,
   input wire logic        CMD_MISS,
   input wire logic        CLEAR_FAULTS,
   input wire logic        CONV_DONE,
   input wire wlr_warn_s   WARN
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);
   read_valid_a: assert property (RD_EN |=> RD_VALID)
      else $error("read not answered");
   no_valid_a: assert property (!RD_EN |=> !RD_VALID)
      else $error("valid without read");
   miss_zero_a: assert property (RD_EN && CMD == 8'h00 |=> CMD_MISS && RD_DATA == 16'h0000)
      else $error("unknown command not refused");
   resv_zero_a: assert property (RD_VALID && $past(CMD) != CMD_PIN_HIGH |-> RD_DATA[15:12] == 4'h0)
      else $error("reserved bits not zero");
   pin_top_a: assert property (RD_VALID |-> !RD_DATA[15])
      else $error("top bit not zero");
   clear_warn_a: assert property (CLEAR_FAULTS && !CONV_DONE |=> WARN == 8'h00)
      else $error("warnings not cleared");
   data_hold_a: assert property (!RD_EN |=> $stable(RD_DATA))
      else $error("read data moved");
   warn_sticky_a: assert property (!CONV_DONE && !CLEAR_FAULTS |=> $stable(WARN))
      else $error("warnings moved without cause");
endmodule : wlr_bank_chk
bind wlr_bank wlr_bank_chk chk_u (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .RD_EN(RD_EN), .CMD(CMD),
   .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .CMD_MISS(CMD_MISS),
   .CLEAR_FAULTS(CLEAR_FAULTS), .CONV_DONE(CONV_DONE), .WARN(WARN));
`default_nettype wire

// *** dv/wlr_bank_tb_top.sv ***
// Register and warning tests for the warning limit bank.
`timescale 1ns/100ps
`default_nettype none
module wlr_bank_tb_top
   import wlr_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic        clear_faults = 1'b0;
   logic [7:0]  cmd = 8'h00;
   logic [15:0] wr_data = 16'h0000;
   logic [15:0] rd_data;
   logic        rd_valid;
   logic        cmd_miss;
   logic        conv_done;
   wlr_meas_s   meas;
   wlr_warn_s   warn;
   int          bad_count = 0;
   int          checks_done = 0;
   int          cycles = 0;
   logic [7:0]  cmds [8] = '{CMD_VOUT_HIGH, CMD_VOUT_LOW, CMD_LOAD_HIGH, CMD_TEMP_FLT,
                             CMD_TEMP_WARN, CMD_VIN_HIGH, CMD_VIN_LOW, CMD_PIN_HIGH};
   always #4 sys_clk = ~sys_clk;
   wlr_conv_src src_u (.clk(sys_clk), .conv_done(conv_done), .meas(meas));
   wlr_bank dut_u (.SYS_CLK(sys_clk), .RSTN(rstn), .WR_EN(wr_en), .RD_EN(rd_en), .CMD(cmd),
      .WR_DATA(wr_data), .RD_DATA(rd_data), .RD_VALID(rd_valid), .CMD_MISS(cmd_miss),
      .CLEAR_FAULTS(clear_faults), .CONV_DONE(conv_done), .MEAS(meas), .WARN(warn));
   task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp16
   task automatic cmp1(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask : cmp1
   // Each access ends with an idle cycle, so the next call never re-raises a strobe at once.
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      cmd = c;
      wr_data = d;
      wr_en = 1'b1;
      @(negedge sys_clk);
      wr_en = 1'b0;
      @(negedge sys_clk);
   endtask : wr
   task automatic rd(input logic [7:0] c, input logic [15:0] exp, input logic miss);
      cmd = c;
      rd_en = 1'b1;
      @(negedge sys_clk);
      rd_en = 1'b0;
      cmp16("read data", exp, rd_data);
      cmp1("read valid", 1'b1, rd_valid);
      cmp1("command miss", miss, cmd_miss);
      @(negedge sys_clk);
      cmp1("valid pulse", 1'b0, rd_valid);
      cmp1("miss pulse", 1'b0, cmd_miss);
   endtask : rd
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   // A healthy run takes about 75 cycles, so the ceiling leaves a wide margin.
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         bad_count++;
         results();
      end
   end
   initial
   begin
      repeat (10) @(negedge sys_clk);
      rstn = 1'b1;
      rd(CMD_VOUT_HIGH, RST_ONES12, 1'b0);
      rd(CMD_VOUT_LOW,  RST_ZERO12, 1'b0);
      rd(CMD_LOAD_HIGH, RST_ONES12, 1'b0);
      rd(CMD_TEMP_FLT,  RST_ONES12, 1'b0);
      rd(CMD_TEMP_WARN, RST_ONES12, 1'b0);
      rd(CMD_VIN_HIGH,  RST_ONES12, 1'b0);
      rd(CMD_VIN_LOW,   RST_ZERO12, 1'b0);
      rd(CMD_PIN_HIGH,  RST_ONES15, 1'b0);
      for (int i = 0; i < 7; i++)
      begin
         wr(cmds[i], 16'hF123);
         rd(cmds[i], 16'h0123, 1'b0);
      end
      wr(CMD_TEMP_FLT, 16'h0456);
      rd(CMD_TEMP_WARN, 16'h0123, 1'b0);
      rd(CMD_TEMP_FLT, 16'h0456, 1'b0);
      wr(CMD_TEMP_FLT, 16'h0123);
      wr(CMD_PIN_HIGH, 16'hFFFF);
      rd(CMD_PIN_HIGH, 16'h7FFF, 1'b0);
      rd(8'h00, 16'h0000, 1'b1);
      src_u.conv(12'h124, 15'h7FFF);
      cmp16("warn high", 16'h00BC, {8'h00, warn});
      clear_faults = 1'b1;
      @(negedge sys_clk);
      clear_faults = 1'b0;
      cmp16("warn clear", 16'h0000, {8'h00, warn});
      src_u.conv(12'h122, 15'h0000);
      cmp16("warn low", 16'h0042, {8'h00, warn});
      @(negedge sys_clk);
      clear_faults = 1'b1;
      src_u.conv(12'h124, 15'h7FFF);
      cmp16("warn kept", 16'h00BC, {8'h00, warn});
      @(negedge sys_clk);
      src_u.conv(12'h123, 15'h7FFF);
      clear_faults = 1'b0;
      cmp16("warn equal", 16'h0000, {8'h00, warn});
      results();
   end
endmodule : wlr_bank_tb_top
`default_nettype wire

// *** dv/wlr_conv_src.sv ***
// Conversion source model that presents one set of measurements per pulse.
`timescale 1ns/100ps
`default_nettype none
module wlr_conv_src
   import wlr_pkg::*;
(
   // Clock and results
   input  wire logic      clk,
   output var  logic      conv_done,
   output var  wlr_meas_s meas
);
   initial conv_done = 1'b0;
   initial meas = '0;
   // Results are scrambled after the pulse so a stale value is never mistaken for a fresh one.
   task automatic conv(input logic [11:0] v, input logic [14:0] p);
      meas = '{v, v, v, v, p};
      conv_done = 1'b1;
      @(negedge clk);
      conv_done = 1'b0;
      meas = ~meas;
   endtask : conv
endmodule : wlr_conv_src
`default_nettype wire

// *** hdl/wlr_bank.sv ***
// Warning and fault threshold bank with conversion comparators and warning latches.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Output voltage high warning, 12 bits read/write, resets to all ones.
// - Output voltage low warning, 12 bits read/write, resets to zero.
// - Load current high warning, 12 bits read/write, resets to all ones.
// - Temperature fault threshold, 12 bits read/write, resets to all ones.
// - Separate temperature warning threshold, 12 bits, resets to all ones.
// - Input voltage high warning, 12 bits read/write, resets to all ones.
// - Input voltage low warning, 12 bits read/write, resets to zero.
// - Input power high warning, 15 bits, resets 0x7FFF, bit 15 reads zero.
// - Upper four reserved bits of 12-bit thresholds always read zero.
// - Clear-faults clears warnings; still-exceeded ones set again next conversion.
module wlr_bank
   import wlr_pkg::*;
(
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RSTN,
   // Register access from the command engine
   input  wire logic        WR_EN,
   input  wire logic        RD_EN,
   input  wire logic [7:0]  CMD,
   input  wire logic [15:0] WR_DATA,
   output var  logic [15:0] RD_DATA,
   output var  logic        RD_VALID,
   output var  logic        CMD_MISS,
   // Clear of latched warnings
   input  wire logic        CLEAR_FAULTS,
   // Conversion results
   input  wire logic        CONV_DONE,
   input  wire wlr_meas_s   MEAS,
   // Latched warnings
   output var  wlr_warn_s   WARN
);

   // ****************************************************************
   // Threshold registers
   // ****************************************************************
   localparam logic [7:0] CMDS [NUM_LIMITS] = '{CMD_VOUT_HIGH, CMD_VOUT_LOW, CMD_LOAD_HIGH,
      CMD_TEMP_FLT, CMD_TEMP_WARN, CMD_VIN_HIGH, CMD_VIN_LOW, CMD_PIN_HIGH};
   localparam logic [15:0] MASKS [NUM_LIMITS] = '{LIM12_MASK, LIM12_MASK, LIM12_MASK,
      LIM12_MASK, LIM12_MASK, LIM12_MASK, LIM12_MASK, LIM15_MASK};
   localparam logic [15:0] RSTS [NUM_LIMITS] = '{RST_ONES12, RST_ZERO12, RST_ONES12,
      RST_ONES12, RST_ONES12, RST_ONES12, RST_ZERO12, RST_ONES15};

   // Each entry of lim already has its reserved bits at zero inside its own register.
   logic [15:0] lim [NUM_LIMITS];
   logic [NUM_LIMITS-1:0] hit;

   // One reset value and mask per entry; index 7 is the 15-bit power field.
   // A command that matches no entry leaves every write enable low, so the write is dropped.
   for (genvar g = 0; g < NUM_LIMITS; g++)
   begin : g_lim
      assign hit[g] = (CMD == CMDS[g]);
      wlr_limit_reg #(
         .MASK      (MASKS[g]),
         .RST_VALUE (RSTS[g])
      ) u_reg (
         .clk     (SYS_CLK),
         .rstn    (RSTN),
         .wr_en   (WR_EN & hit[g]),
         .wr_data (WR_DATA),
         .value   (lim[g])
      );
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   // Read data are held between reads, so the protocol engine may fetch them late.
   logic [15:0] next_rd_data;
   logic        next_rd_valid;
   logic        next_cmd_miss;

   always_comb
   begin
      next_rd_data  = RD_DATA;
      next_rd_valid = 1'b0;
      next_cmd_miss = 1'b0;
      if (RD_EN)
      begin
         next_rd_valid = 1'b1;
         unique case (CMD)
            CMD_VOUT_HIGH:
            begin
               next_rd_data = lim[0] & MASKS[0];
            end
            CMD_VOUT_LOW:
            begin
               next_rd_data = lim[1] & MASKS[1];
            end
            CMD_LOAD_HIGH:
            begin
               next_rd_data = lim[2] & MASKS[2];
            end
            CMD_TEMP_FLT:
            begin
               next_rd_data = lim[3] & MASKS[3];
            end
            CMD_TEMP_WARN:
            begin
               next_rd_data = lim[4] & MASKS[4];
            end
            CMD_VIN_HIGH:
            begin
               next_rd_data = lim[5] & MASKS[5];
            end
            CMD_VIN_LOW:
            begin
               next_rd_data = lim[6] & MASKS[6];
            end
            // The power entry keeps three more field bits; its bit 15 still reads zero.
            CMD_PIN_HIGH:
            begin
               next_rd_data = lim[7] & MASKS[7];
            end
            default:
            begin
               next_rd_data = 16'h0000;
            end
         endcase
      end
      // An unknown command reads as zero and is flagged for the protocol engine.
      if ((RD_EN || WR_EN) && (hit == '0))
      begin
         next_cmd_miss = 1'b1;
      end
   end

   // RD_VALID is a one-cycle pulse, while RD_DATA stands until the next read.
   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         RD_DATA  <= 16'h0000;
         RD_VALID <= 1'b0;
         CMD_MISS <= 1'b0;
      end
      else
      begin
         RD_DATA  <= next_rd_data;
         RD_VALID <= next_rd_valid;
         CMD_MISS <= next_cmd_miss;
      end
   end

   // ****************************************************************
   // Comparators
   // ****************************************************************
   // Strict comparisons: a result equal to its threshold raises no warning.
   function automatic logic above(input logic [14:0] meas, input logic [15:0] limit);
      above = ({1'b0, meas} > limit);
   endfunction : above

   function automatic logic below(input logic [14:0] meas, input logic [15:0] limit);
      below = ({1'b0, meas} < limit);
   endfunction : below

   // Each 12-bit result is widened once, so one pair of functions serves every channel.
   logic [14:0] vout_w;
   logic [14:0] load_w;
   logic [14:0] temp_w;
   logic [14:0] vin_w;
   wlr_warn_s   exceed;

   assign vout_w = {3'h0, MEAS.vout};
   assign load_w = {3'h0, MEAS.load};
   assign temp_w = {3'h0, MEAS.temp};
   assign vin_w  = {3'h0, MEAS.vin};

   always_comb
   begin
      exceed.vout_high = above(vout_w,   lim[0]);
      exceed.vout_low  = below(vout_w,   lim[1]);
      exceed.load_high = above(load_w,   lim[2]);
      exceed.temp_flt  = above(temp_w,   lim[3]);
      exceed.temp_warn = above(temp_w,   lim[4]);
      exceed.vin_high  = above(vin_w,    lim[5]);
      exceed.vin_low   = below(vin_w,    lim[6]);
      exceed.pin_high  = above(MEAS.pin, lim[7]);
   end

   // ****************************************************************
   // Warning latches
   // ****************************************************************
   // Warnings stay set until a clear, so an excursion between two host polls is never missed.
   wlr_warn_s next_warn;

   // A conversion in the same cycle as a clear wins, so no event is lost.
   always_comb
   begin
      next_warn = WARN;
      if (CLEAR_FAULTS)
      begin
         next_warn = '0;
      end
      if (CONV_DONE)
      begin
         next_warn = next_warn | exceed;
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RSTN)
      begin
         WARN <= '0;
      end
      else
      begin
         WARN <= next_warn;
      end
   end

endmodule : wlr_bank
`default_nettype wire

// *** hdl/wlr_limit_reg.sv ***
// One read/write threshold register with a masked field and reserved bits forced to zero.
`timescale 1ns/100ps
`default_nettype none
module wlr_limit_reg
   import wlr_pkg::*;
#(
   parameter logic [15:0] MASK      = LIM12_MASK,
   parameter logic [15:0] RST_VALUE = RST_ONES12
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Write port
   input  wire logic        wr_en,
   input  wire logic [15:0] wr_data,
   // Stored value
   output var  logic [15:0] value
);

   logic [15:0] next_value;

   // Reserved bits are never stored, so they always read back as zero.
   always_comb
   begin
      next_value = value;
      if (wr_en)
      begin
         next_value = wr_data & MASK;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         value <= RST_VALUE & MASK;
      end
      else
      begin
         value <= next_value;
      end
   end

endmodule : wlr_limit_reg
`default_nettype wire

// *** hdl/wlr_pkg.sv ***
// Package of register map, field layouts, reset values and carriers for the warning limit bank.
package wlr_pkg;

   // ****************************************************************
   // Register command codes
   // ****************************************************************
   localparam logic [7:0] CMD_VOUT_HIGH = 8'h42;
   localparam logic [7:0] CMD_VOUT_LOW  = 8'h43;
   localparam logic [7:0] CMD_LOAD_HIGH = 8'h4A;
   localparam logic [7:0] CMD_TEMP_FLT  = 8'h4F;
   localparam logic [7:0] CMD_TEMP_WARN = 8'h51;
   localparam logic [7:0] CMD_VIN_HIGH  = 8'h57;
   localparam logic [7:0] CMD_VIN_LOW   = 8'h58;
   localparam logic [7:0] CMD_PIN_HIGH  = 8'h6B;

   // ****************************************************************
   // Field layouts and reset values
   // ****************************************************************
   localparam int          LIM12_W     = 12;
   localparam int          LIM15_W     = 15;
   localparam logic [15:0] LIM12_MASK  = 16'h0FFF;
   localparam logic [15:0] LIM15_MASK  = 16'h7FFF;
   localparam logic [15:0] RST_ONES12  = 16'h0FFF;
   localparam logic [15:0] RST_ZERO12  = 16'h0000;
   localparam logic [15:0] RST_ONES15  = 16'h7FFF;
   localparam int          NUM_LIMITS  = 8;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed
   {
      logic [11:0] vout;
      logic [11:0] load;
      logic [11:0] temp;
      logic [11:0] vin;
      logic [14:0] pin;
   } wlr_meas_s;

   typedef struct packed
   {
      logic vout_high;
      logic vout_low;
      logic load_high;
      logic temp_flt;
      logic temp_warn;
      logic vin_high;
      logic vin_low;
      logic pin_high;
   } wlr_warn_s;

endpackage : wlr_pkg
